// ---- iopdi_port.sv ----
`timescale 1ns/1ps
// Functional notes
// - each pin has a three-bit drive mode held in port drive mode registers
// - mode 0 turns off driver and input buffer; pin floats
// - mode 0 pin gives no digital input to system or readback
// - after reset every pin is mode 0
// - mode 1 leaves output undriven and enables input buffer
// - mode 2 resistive high/strong low; mode 3 strong high/resistive low
// - mode 4 float/strong low; mode 5 strong high/float
// - mode 6 drives strongly to the data value
// - mode 7 resistive high and resistive low, never strong
// - data comes from output data register or logic-array signal in bypass
// - special pins in regulated output refuse resistive modes
// - port-form view maps each bit to one pin
// - pin-form view gathers eight bits per pin, consistent with port form
// - bidirectional: aux signal picks digital input or programmed mode
// - aux bus carries 16 output enables, each routable to pins
// - per-pin slew select, only for strong and open-drain modes
// - all eight pins feed one interrupt unit with its own request line
// - per-pin edge select: rising, falling, both, or off
// - configured edge sets the pin status bit and raises the request
// - no level-sensitive detection in the interrupt unit
// - one port setting selects CMOS or LVTTL thresholds
// - per-pin input buffer disable forces the digital input inactive
// - separate pin-state read register from output data register
module iopdi_port #(
  parameter bit SPECIAL_PINS = 1'b0
) (
  // clock and reset
  input  wire logic                                     SYS_CLK,
  input  wire logic                                     RST_N,
  // axi4-lite write address, data and response
  input  wire logic [7:0]                               S_AXI_AWADDR,
  input  wire logic                                     S_AXI_AWVALID,
  output      logic                                     S_AXI_AWREADY,
  input  wire logic [31:0]                              S_AXI_WDATA,
  input  wire logic [3:0]                               S_AXI_WSTRB,
  input  wire logic                                     S_AXI_WVALID,
  output      logic                                     S_AXI_WREADY,
  output      logic [1:0]                               S_AXI_BRESP,
  output      logic                                     S_AXI_BVALID,
  input  wire logic                                     S_AXI_BREADY,
  // axi4-lite read
  input  wire logic [7:0]                               S_AXI_ARADDR,
  input  wire logic                                     S_AXI_ARVALID,
  output      logic                                     S_AXI_ARREADY,
  output      logic [31:0]                              S_AXI_RDATA,
  output      logic [1:0]                               S_AXI_RRESP,
  output      logic                                     S_AXI_RVALID,
  input  wire logic                                     S_AXI_RREADY,
  // logic array side
  input  wire logic [iopdi_pkg::PINS-1:0]               ARRAY_OUT,
  input  wire logic [iopdi_pkg::OE_LINES-1:0]           AUX_OE,
  output      logic [iopdi_pkg::PINS-1:0]               ARRAY_IN,
  // pad side
  input  wire logic [iopdi_pkg::PINS-1:0]               PAD_IN,
  input  wire logic                                     REGULATED_OUT,
  output      iopdi_pkg::iopdi_drive_s [iopdi_pkg::PINS-1:0] PAD_DRIVE,
  output      logic                                     LVTTL_SEL,
  // port interrupt request
  output      logic                                     PIN_IRQ
);
  localparam int N = iopdi_pkg::PINS;

  if (iopdi_pkg::OE_LINES != (1 << iopdi_pkg::OE_SEL_W)) begin : g_bad_oe
    $error("aux bus width must match selector width");
  end

  // ==========================================================
  // registers
  logic [N-1:0] port_output_data_reg;
  logic [N-1:0] drive_mode_bit_zero;
  logic [N-1:0] drive_mode_bit_one;
  logic [N-1:0] drive_mode_bit_two;
  logic [N-1:0] port_slew_select_reg;
  logic [N-1:0] bypass;
  logic [N-1:0] bidir;
  logic [N-1:0] in_disable;
  logic         lvttl;
  logic [2*N-1:0] irq_type;
  logic [N-1:0] irq_stat;
  logic [iopdi_pkg::OE_SEL_W*N-1:0] oe_sel;
  logic [N-1:0] sync1;
  logic [N-1:0] sync2;
  logic [N-1:0] prev;

  // ==========================================================
  // axi4-lite slave: write taken once both channels are present
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  wire         do_write = aw_held && w_held && !S_AXI_BVALID;
  assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
  assign S_AXI_WREADY  = !w_held && !S_AXI_BVALID;
  assign S_AXI_ARREADY = !S_AXI_RVALID;
  wire         do_read  = S_AXI_ARVALID && S_AXI_ARREADY;
  wire [7:0]   wa = aw_addr;
  wire [7:0]   ra = S_AXI_ARADDR;
  wire         wb0 = w_strb[0];

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
      end
    end
  end

  // address decode
  wire w_pin  = (wa >= iopdi_pkg::OFF_PIN_BASE) && (wa <= iopdi_pkg::OFF_PIN_LAST) && (wa[1:0] == 2'h0);
  wire r_pin  = (ra >= iopdi_pkg::OFF_PIN_BASE) && (ra <= iopdi_pkg::OFF_PIN_LAST) && (ra[1:0] == 2'h0);
  wire [2:0] w_idx = 3'((wa - iopdi_pkg::OFF_PIN_BASE) >> 2);
  wire [2:0] r_idx = 3'((ra - iopdi_pkg::OFF_PIN_BASE) >> 2);
  wire w_map = w_pin || (wa == iopdi_pkg::OFF_DATA) || (wa == iopdi_pkg::OFF_STATE)
            || (wa == iopdi_pkg::OFF_DM0) || (wa == iopdi_pkg::OFF_DM1) || (wa == iopdi_pkg::OFF_DM2)
            || (wa == iopdi_pkg::OFF_SLEW) || (wa == iopdi_pkg::OFF_BYPASS) || (wa == iopdi_pkg::OFF_BIDIR)
            || (wa == iopdi_pkg::OFF_INDIS) || (wa == iopdi_pkg::OFF_CTL) || (wa == iopdi_pkg::OFF_IRQ_TYPE)
            || (wa == iopdi_pkg::OFF_IRQ_STAT) || (wa == iopdi_pkg::OFF_OE_SEL_LO)
            || (wa == iopdi_pkg::OFF_OE_SEL_HI);

  // ==========================================================
  // pin-form view is built from the same flops, so both views always agree
  logic [N-1:0] pin_state;
  logic [7:0]   pin_word [N];
  for (genvar p = 0; p < N; p++) begin : g_pinform
    assign pin_word[p] = {bidir[p], bypass[p], port_slew_select_reg[p], drive_mode_bit_two[p],
                          drive_mode_bit_one[p], drive_mode_bit_zero[p], pin_state[p],
                          port_output_data_reg[p]};
  end

  // one-hot write strobe per pin for pin form
  wire          wr_lane = do_write && wb0;
  wire [N-1:0]  pin_hit = (wr_lane && w_pin) ? (N'(1) << w_idx) : '0;
  wire [7:0]    wd = w_data[7:0];

  // bitwise next value: port form replaces all bits, pin form replaces one
  function automatic logic [N-1:0] upd(input logic [N-1:0] cur, input logic port_hit, input int pos);
    logic [N-1:0] r;
    r = cur;
    if (port_hit) begin
      r = wd;
    end
    for (int i = 0; i < N; i++) begin
      if (pin_hit[i]) begin
        r[i] = wd[pos];
      end
    end
    return r;
  endfunction

  wire p_data = wr_lane && (wa == iopdi_pkg::OFF_DATA);
  wire p_dm0  = wr_lane && (wa == iopdi_pkg::OFF_DM0);
  wire p_dm1  = wr_lane && (wa == iopdi_pkg::OFF_DM1);
  wire p_dm2  = wr_lane && (wa == iopdi_pkg::OFF_DM2);
  wire p_slw  = wr_lane && (wa == iopdi_pkg::OFF_SLEW);
  wire p_byp  = wr_lane && (wa == iopdi_pkg::OFF_BYPASS);
  wire p_bid  = wr_lane && (wa == iopdi_pkg::OFF_BIDIR);
  wire p_ind  = wr_lane && (wa == iopdi_pkg::OFF_INDIS);
  wire p_ctl  = wr_lane && (wa == iopdi_pkg::OFF_CTL);

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      port_output_data_reg <= iopdi_pkg::RST_BYTE;
      drive_mode_bit_zero  <= iopdi_pkg::RST_BYTE;
      drive_mode_bit_one   <= iopdi_pkg::RST_BYTE;
      drive_mode_bit_two   <= iopdi_pkg::RST_BYTE;
      port_slew_select_reg <= iopdi_pkg::RST_BYTE;
      bypass               <= iopdi_pkg::RST_BYTE;
      bidir                <= iopdi_pkg::RST_BYTE;
      in_disable           <= iopdi_pkg::RST_BYTE;
      lvttl                <= 1'b0;
      irq_type             <= '0;
      oe_sel               <= '0;
    end else begin
      port_output_data_reg <= upd(port_output_data_reg, p_data, iopdi_pkg::PF_DATA);
      drive_mode_bit_zero  <= upd(drive_mode_bit_zero, p_dm0, iopdi_pkg::PF_DM_LO);
      drive_mode_bit_one   <= upd(drive_mode_bit_one, p_dm1, iopdi_pkg::PF_DM_LO + 1);
      drive_mode_bit_two   <= upd(drive_mode_bit_two, p_dm2, iopdi_pkg::PF_DM_LO + 2);
      port_slew_select_reg <= upd(port_slew_select_reg, p_slw, iopdi_pkg::PF_SLEW);
      bypass               <= upd(bypass, p_byp, iopdi_pkg::PF_BYPASS);
      bidir                <= upd(bidir, p_bid, iopdi_pkg::PF_BIDIR);
      if (p_ind) begin
        in_disable <= wd;
      end
      if (p_ctl) begin
        lvttl <= wd[0];
      end
      if (do_write && (wa == iopdi_pkg::OFF_IRQ_TYPE)) begin
        irq_type <= w_data[2*N-1:0];
      end
      if (do_write && (wa == iopdi_pkg::OFF_OE_SEL_LO)) begin
        oe_sel[15:0] <= w_data[15:0];
      end
      if (do_write && (wa == iopdi_pkg::OFF_OE_SEL_HI)) begin
        oe_sel[31:16] <= w_data[15:0];
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= iopdi_pkg::RESP_OKAY;
    end else if (do_write) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP  <= w_map ? iopdi_pkg::RESP_OKAY : iopdi_pkg::RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // ==========================================================
  // drive mode decode per pin
  iopdi_pkg::iopdi_drive_s [N-1:0] drv;
  logic [N-1:0] in_live;
  for (genvar p = 0; p < N; p++) begin : g_pin
    wire [2:0] prog_mode = {drive_mode_bit_two[p], drive_mode_bit_one[p], drive_mode_bit_zero[p]};
    wire       oe_on     = AUX_OE[oe_sel[iopdi_pkg::OE_SEL_W*p +: iopdi_pkg::OE_SEL_W]];
    // bidirectional pins fall back to digital input while their enable is low
    wire [2:0] eff_mode  = (bidir[p] && !oe_on) ? iopdi_pkg::DM_HIZ_DIGITAL : prog_mode;
    wire       dval      = bypass[p] ? ARRAY_OUT[p] : port_output_data_reg[p];
    wire       res_ok    = !(SPECIAL_PINS && REGULATED_OUT);
    iopdi_pkg::iopdi_drive_s d;
    always_comb begin
      d = '0;
      d.in_en = !in_disable[p];
      case (iopdi_pkg::iopdi_mode_e'(eff_mode))
        iopdi_pkg::DM_HIZ_ANALOG: begin
          d.in_en = 1'b0;
        end
        iopdi_pkg::DM_HIZ_DIGITAL: begin
          d.in_en = !in_disable[p];
        end
        iopdi_pkg::DM_RES_UP: begin
          d.res_hi    = dval && res_ok;
          d.strong_lo = !dval;
        end
        iopdi_pkg::DM_RES_DOWN: begin
          d.strong_hi = dval;
          d.res_lo    = !dval && res_ok;
        end
        iopdi_pkg::DM_OD_LOW: begin
          d.strong_lo = !dval;
        end
        iopdi_pkg::DM_OD_HIGH: begin
          d.strong_hi = dval;
        end
        iopdi_pkg::DM_STRONG: begin
          d.strong_hi = dval;
          d.strong_lo = !dval;
        end
        default: begin
          d.res_hi = dval && res_ok;
          d.res_lo = !dval && res_ok;
        end
      endcase
      // slew only matters in modes 4 to 6; resistive drive and the strong edges of modes 2 and 3 ignore it
      d.slow = port_slew_select_reg[p] && (eff_mode >= iopdi_pkg::DM_OD_LOW)
               && (eff_mode != iopdi_pkg::DM_RES_BOTH);
    end
    assign drv[p]     = d;
    assign in_live[p] = d.in_en;
  end
  assign PAD_DRIVE = drv;
  assign LVTTL_SEL = lvttl;

  // ==========================================================
  // input sampling and edge detection
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      sync1 <= '0;
      sync2 <= '0;
      prev  <= '0;
    end else begin
      sync1 <= PAD_IN;
      sync2 <= sync1;
      prev  <= sync2 & in_live;
    end
  end
  assign pin_state = sync2 & in_live;
  assign ARRAY_IN  = pin_state;

  // edges only, no level terms here; level behaviour belongs to external logic
  logic [N-1:0] edge_hit;
  for (genvar p = 0; p < N; p++) begin : g_edge
    wire [1:0] t = irq_type[2*p +: 2];
    assign edge_hit[p] = ((t == iopdi_pkg::EDGE_RISE || t == iopdi_pkg::EDGE_BOTH) && pin_state[p] && !prev[p])
                      || ((t == iopdi_pkg::EDGE_FALL || t == iopdi_pkg::EDGE_BOTH) && !pin_state[p] && prev[p]);
  end

  wire          stat_rd    = do_read && (ra == iopdi_pkg::OFF_IRQ_STAT);
  wire [N-1:0]  next_stat  = (stat_rd ? '0 : irq_stat) | edge_hit;
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= next_stat;
    end
  end
  assign PIN_IRQ = |irq_stat;

  // ==========================================================
  // read path
  logic [31:0] rd_val;
  logic        rd_ok;
  always_comb begin
    rd_ok  = 1'b1;
    rd_val = 32'h0000_0000;
    if (r_pin) begin
      rd_val[7:0] = pin_word[r_idx];
    end else if (ra == iopdi_pkg::OFF_DATA) begin
      rd_val[7:0] = port_output_data_reg;
    end else if (ra == iopdi_pkg::OFF_STATE) begin
      rd_val[7:0] = pin_state;
    end else if (ra == iopdi_pkg::OFF_DM0) begin
      rd_val[7:0] = drive_mode_bit_zero;
    end else if (ra == iopdi_pkg::OFF_DM1) begin
      rd_val[7:0] = drive_mode_bit_one;
    end else if (ra == iopdi_pkg::OFF_DM2) begin
      rd_val[7:0] = drive_mode_bit_two;
    end else if (ra == iopdi_pkg::OFF_SLEW) begin
      rd_val[7:0] = port_slew_select_reg;
    end else if (ra == iopdi_pkg::OFF_BYPASS) begin
      rd_val[7:0] = bypass;
    end else if (ra == iopdi_pkg::OFF_BIDIR) begin
      rd_val[7:0] = bidir;
    end else if (ra == iopdi_pkg::OFF_INDIS) begin
      rd_val[7:0] = in_disable;
    end else if (ra == iopdi_pkg::OFF_CTL) begin
      rd_val[0] = lvttl;
    end else if (ra == iopdi_pkg::OFF_IRQ_TYPE) begin
      rd_val[2*N-1:0] = irq_type;
    end else if (ra == iopdi_pkg::OFF_IRQ_STAT) begin
      rd_val[7:0] = irq_stat;
    end else if (ra == iopdi_pkg::OFF_OE_SEL_LO) begin
      rd_val[15:0] = oe_sel[15:0];
    end else if (ra == iopdi_pkg::OFF_OE_SEL_HI) begin
      rd_val[15:0] = oe_sel[31:16];
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h0000_0000;
      S_AXI_RRESP  <= iopdi_pkg::RESP_OKAY;
    end else if (do_read) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA  <= rd_val;
      S_AXI_RRESP  <= rd_ok ? iopdi_pkg::RESP_OKAY : iopdi_pkg::RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  // ==========================================================
  // checks
  chk_mode0_float: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    ({drive_mode_bit_two[0], drive_mode_bit_one[0], drive_mode_bit_zero[0]} == 3'h0 && !bidir[0])
    |-> (PAD_DRIVE[0] == '0)) else $error("mode 0 pin not floating");
  chk_mode0_noin: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    ({drive_mode_bit_two[1], drive_mode_bit_one[1], drive_mode_bit_zero[1]} == 3'h0 && !bidir[1])
    |-> !ARRAY_IN[1]) else $error("mode 0 pin gives input");
  chk_reset_mode: assert property (@(posedge SYS_CLK)
    !RST_N |=> (drive_mode_bit_zero == 8'h00 && drive_mode_bit_one == 8'h00 && drive_mode_bit_two == 8'h00))
    else $error("mode not reset");
  chk_strong_drive: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    ({drive_mode_bit_two[3], drive_mode_bit_one[3], drive_mode_bit_zero[3]} == 3'h6 && !bidir[3] && !bypass[3])
    |-> (PAD_DRIVE[3].strong_hi == port_output_data_reg[3] && PAD_DRIVE[3].strong_lo != port_output_data_reg[3]))
    else $error("strong drive wrong");
  chk_res_never_strong: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    ({drive_mode_bit_two[7], drive_mode_bit_one[7], drive_mode_bit_zero[7]} == 3'h7 && !bidir[7])
    |-> !(PAD_DRIVE[7].strong_hi || PAD_DRIVE[7].strong_lo)) else $error("mode 7 strong");
  chk_indis_off: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    in_disable[1] |-> !ARRAY_IN[1]) else $error("disabled input live");
  chk_rise_sets: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (irq_type[5:4] == iopdi_pkg::EDGE_RISE && pin_state[2] && !prev[2]) |=> (irq_stat[2] && PIN_IRQ))
    else $error("rising edge lost");
  chk_stat_clear: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (stat_rd && edge_hit == '0) |=> (irq_stat == '0 && !PIN_IRQ)) else $error("status not cleared");
  chk_sync_delay: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    $rose(sync2[5]) |-> $past(sync1[5])) else $error("sync path broken");
  cov_write: cover property (@(posedge SYS_CLK) do_write);
  cov_irq: cover property (@(posedge SYS_CLK) $rose(PIN_IRQ));
  cov_bidir: cover property (@(posedge SYS_CLK) bidir != '0 && AUX_OE != '0);
endmodule

// ---- iopdi_pkg.sv ----
package iopdi_pkg;
  // ==========================================================
  // sizes
  localparam int PINS        = 8;
  localparam int OE_LINES    = 16;
  localparam int OE_SEL_W    = 4;
  localparam int MODE_W      = 3;
  // ==========================================================
  // register byte offsets, port-form except the pin-form words from OFF_PIN_BASE
  localparam logic [7:0] OFF_DATA      = 8'h00;
  localparam logic [7:0] OFF_STATE     = 8'h04;
  localparam logic [7:0] OFF_DM0       = 8'h08;
  localparam logic [7:0] OFF_DM1       = 8'h0c;
  localparam logic [7:0] OFF_DM2       = 8'h10;
  localparam logic [7:0] OFF_SLEW      = 8'h14;
  localparam logic [7:0] OFF_BYPASS    = 8'h18;
  localparam logic [7:0] OFF_BIDIR     = 8'h1c;
  localparam logic [7:0] OFF_INDIS     = 8'h20;
  localparam logic [7:0] OFF_CTL       = 8'h24;
  localparam logic [7:0] OFF_IRQ_TYPE  = 8'h28;
  localparam logic [7:0] OFF_IRQ_STAT  = 8'h2c;
  localparam logic [7:0] OFF_OE_SEL_LO = 8'h30;
  localparam logic [7:0] OFF_OE_SEL_HI = 8'h34;
  localparam logic [7:0] OFF_PIN_BASE  = 8'h40;
  localparam logic [7:0] OFF_PIN_LAST  = 8'h5c;
  // ==========================================================
  // pin-form field positions
  localparam int PF_DATA   = 0;
  localparam int PF_STATE  = 1;
  localparam int PF_DM_LO  = 2;
  localparam int PF_SLEW   = 5;
  localparam int PF_BYPASS = 6;
  localparam int PF_BIDIR  = 7;
  // ==========================================================
  // answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // drive mode codes
  typedef enum logic [2:0] {
    DM_HIZ_ANALOG = 3'h0,
    DM_HIZ_DIGITAL = 3'h1,
    DM_RES_UP = 3'h2,
    DM_RES_DOWN = 3'h3,
    DM_OD_LOW = 3'h4,
    DM_OD_HIGH = 3'h5,
    DM_STRONG = 3'h6,
    DM_RES_BOTH = 3'h7
  } iopdi_mode_e;
  // edge selection codes
  localparam logic [1:0] EDGE_OFF  = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  // ==========================================================
  // per-pin driver state handed to the pad
  typedef struct packed {
    logic strong_hi;
    logic strong_lo;
    logic res_hi;
    logic res_lo;
    logic in_en;
    logic slow;
  } iopdi_drive_s;
endpackage

// ---- iopdi_pads.sv ----
`timescale 1ns/1ps
// ==========================================================
// circuits on the pads; a pad nobody drives reads the inverse
// of the last external level, so a float never looks stable
module iopdi_pads (
  // device drive
  input  wire iopdi_pkg::iopdi_drive_s [iopdi_pkg::PINS-1:0] drv,
  // external source
  input  wire logic [7:0]                                   ext_en,
  input  wire logic [7:0]                                   ext_val,
  output      logic [7:0]                                   pad
);
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (drv[i].strong_hi | drv[i].strong_lo) pad[i] = drv[i].strong_hi;
      else if (ext_en[i]) pad[i] = ext_val[i];
      else if (drv[i].res_hi | drv[i].res_lo) pad[i] = drv[i].res_hi;
      else pad[i] = ~ext_val[i];
    end
  end
endmodule

// ---- tb.sv ----
`timescale 1ns/1ps
module tb;
  logic                          SYS_CLK, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic                          arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
  logic                          irq, lvttl, reg_out = 1'b0;
  logic [7:0]                    awaddr = 8'h00, araddr = 8'h00, ext_en = 8'h00, ext_val = 8'h00;
  logic [7:0]                    arr_out = 8'h00, pad, arr_in;
  logic [31:0]                   wdata = 32'h0, rdata, tmp_d;
  logic [15:0]                   aux_oe = 16'h0000;
  logic [3:0]                    wstrb = 4'hf;
  logic [1:0]                    bresp, rresp, tmp_r, wr_resp;
  iopdi_pkg::iopdi_drive_s [7:0] drv;
  int                            n_fail = 0, num_checks = 0, cyc = 0;
  iopdi_port #(.SPECIAL_PINS(1'b1)) DUT (.SYS_CLK(SYS_CLK), .RST_N(rst_n), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .ARRAY_OUT(arr_out),
    .AUX_OE(aux_oe), .ARRAY_IN(arr_in), .PAD_IN(pad), .REGULATED_OUT(reg_out), .PAD_DRIVE(drv),
    .LVTTL_SEL(lvttl), .PIN_IRQ(irq));
  iopdi_pads PADS (.drv(drv), .ext_en(ext_en), .ext_val(ext_val), .pad(pad));
  initial begin
    SYS_CLK = 1'b0;
    forever #20 SYS_CLK = ~SYS_CLK;
  end
  // ==========================================================
  // bus tasks: handshakes are judged just before the edge they belong to
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb_;
    @(posedge SYS_CLK);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1; tb_ = 1'b0;
    while (!tb_) begin
      @(negedge SYS_CLK);
      ta = awvalid & awready; tw = wvalid & wready; tb_ = bvalid; wr_resp = bresp;
      @(posedge SYS_CLK);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb_) bready <= 1'b0;
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    @(posedge SYS_CLK);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1; tr = 1'b0;
    while (!tr) begin
      @(negedge SYS_CLK);
      ta = arvalid & arready; tr = rvalid; d = rdata; r = rresp;
      @(posedge SYS_CLK);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk({r, d}, {iopdi_pkg::RESP_OKAY, exp});
  endtask
  // pin i holds mode i; nibble i is {strong_hi, strong_lo, res_hi, res_lo}
  task automatic pads(input logic d);
    logic [31:0] t;
    t = d ? 32'h28808200 : 32'h14041400;
    @(negedge SYS_CLK);
    for (int i = 0; i < 8; i++) begin
      chk({drv[i].strong_hi, drv[i].strong_lo, drv[i].res_hi, drv[i].res_lo}, t[4*i+:4]);
      chk(drv[i].in_en, i != 0);
      if (i > 3 && i < 7) chk(drv[i].slow, 1'b1);
    end
  endtask
  task automatic summarize;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge SYS_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      summarize();
    end
  end
  // ==========================================================
  // scenarios
  initial begin
    repeat (2) @(posedge SYS_CLK);
    rst_n <= 1'b1;
    @(posedge SYS_CLK);
    chk(drv, 48'h0);
    for (int a = 0; a < 'h38; a += 4) rc(8'(a), 32'h0);
    wr(iopdi_pkg::OFF_DM0, 32'haa);
    wr(iopdi_pkg::OFF_DM1, 32'hcc);
    wr(iopdi_pkg::OFF_DM2, 32'hf0);
    wr(iopdi_pkg::OFF_SLEW, 32'hff);
    for (int d = 0; d < 2; d++) begin
      wr(iopdi_pkg::OFF_DATA, d ? 32'hff : 32'h0);
      pads(d[0]);
    end
    @(posedge SYS_CLK);
    reg_out <= 1'b1;
    @(negedge SYS_CLK);
    chk({drv[7].res_hi, drv[3].strong_hi, drv[2].res_hi}, 3'b010);
    @(posedge SYS_CLK);
    reg_out <= 1'b0;
    rc(8'h44, 32'h27);
    wr(8'h4c, 32'h19);
    rc(iopdi_pkg::OFF_DM0, 32'ha2);
    rc(iopdi_pkg::OFF_DM2, 32'hf8);
    rc(iopdi_pkg::OFF_SLEW, 32'hf7);
    arr_out <= 8'h40;
    wr(iopdi_pkg::OFF_DATA, 32'h0);
    wr(iopdi_pkg::OFF_BYPASS, 32'h40);
    @(negedge SYS_CLK);
    chk({drv[6].strong_hi, drv[5].strong_hi}, 2'b10);
    wr(iopdi_pkg::OFF_BIDIR, 32'h40);
    wr(iopdi_pkg::OFF_OE_SEL_HI, 32'h0f00);
    aux_oe <= 16'h7fff;
    @(negedge SYS_CLK);
    chk({drv[6].strong_hi, drv[6].strong_lo, drv[6].in_en}, 3'b001);
    @(posedge SYS_CLK);
    aux_oe <= 16'h8000;
    arr_out <= 8'h00;
    @(negedge SYS_CLK);
    chk({drv[6].strong_hi, drv[6].strong_lo}, 2'b01);
    wr(iopdi_pkg::OFF_CTL, 32'h1);
    chk(wr_resp, iopdi_pkg::RESP_OKAY);
    wr(8'h3c, 32'h0);
    chk(wr_resp, iopdi_pkg::RESP_SLVERR);
    rd(8'h3c, tmp_d, tmp_r);
    chk({tmp_r, tmp_d}, {iopdi_pkg::RESP_SLVERR, 32'h0});
    chk(lvttl, 1'b1);
    wr(iopdi_pkg::OFF_DM2, 32'h0);
    wr(iopdi_pkg::OFF_DM1, 32'h0);
    wr(iopdi_pkg::OFF_DM0, 32'hfe);
    ext_en <= 8'hff;
    ext_val <= 8'h5b;
    wr(iopdi_pkg::OFF_INDIS, 32'h02);
    repeat (4) @(negedge SYS_CLK);
    chk(arr_in, 8'h58);
    rc(iopdi_pkg::OFF_STATE, 32'h58);
    ext_val <= 8'h00;
    wr(iopdi_pkg::OFF_IRQ_TYPE, 32'h390);
    rc(iopdi_pkg::OFF_IRQ_STAT, 32'h0);
    ext_val <= 8'h3c;
    repeat (4) @(negedge SYS_CLK);
    chk(irq, 1'b1);
    rc(iopdi_pkg::OFF_IRQ_STAT, 32'h14);
    @(negedge SYS_CLK);
    chk(irq, 1'b0);
    rc(iopdi_pkg::OFF_IRQ_STAT, 32'h0);
    ext_val <= 8'h00;
    repeat (4) @(posedge SYS_CLK);
    rc(iopdi_pkg::OFF_IRQ_STAT, 32'h18);
    summarize();
  end
endmodule
